// File: adcsq_defines.svh
// Offsets, bit positions, reset values and cycle counts of the sequencer.
// Assumes inclusion by its bare name from package and design files.
`ifndef ADCSQ_DEFINES_SVH
`define ADCSQ_DEFINES_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define ADCSQ_OFS_CONFIG 8'h00
`define ADCSQ_OFS_TIMER 8'h04
`define ADCSQ_OFS_STATUS 8'h08
`define ADCSQ_RAM_BASE_HI 3'h1
`define ADCSQ_ADR_W 8

// ****************************************
// Configuration bits
// ****************************************
`define ADCSQ_CFG_START 0
`define ADCSQ_CFG_RESET 1
`define ADCSQ_CFG_SHORT_CAL 2
`define ADCSQ_CFG_FULL_CAL 3
`define ADCSQ_CFG_SHORT_CAL_ALT 6
`define ADCSQ_CFG_RESET_VAL 16'h0000

// ****************************************
// Instruction word bits
// ****************************************
`define ADCSQ_INS_PAUSE 0
`define ADCSQ_INS_LOOP 1
`define ADCSQ_INS_REDUCED 8
`define ADCSQ_INS_TIMER_EN 9
`define ADCSQ_INS_WATCH 11
`define ADCSQ_INS_ACQ_LO 12
`define ADCSQ_INS_RESET_VAL 16'h0000

// ****************************************
// Status bits
// ****************************************
`define ADCSQ_STAT_RUN 0
`define ADCSQ_STAT_CAL 1
`define ADCSQ_STAT_PAUSED 2
`define ADCSQ_STAT_IP_LO 8

// ****************************************
// State durations in clock cycles
// ****************************************
`define ADCSQ_SHORT_CAL_CYC 76
`define ADCSQ_FULL_CAL_CYC 4944
`define ADCSQ_TMR_MUL 32
`define ADCSQ_TMR_ADD 2
`define ADCSQ_ACQ_FULL_ADD 9
`define ADCSQ_ACQ_RED_ADD 2
`define ADCSQ_CMP1_CYC 5
`define ADCSQ_LIM2_CYC 1
`define ADCSQ_CONV_FULL_CYC 44
`define ADCSQ_CONV_RED_CYC 21
`define ADCSQ_CONV_WATCH_CYC 5
`define ADCSQ_CNT_W 22

`endif

// File: adcsq_pkg.sv
// Types shared by the sequencer, its checker, core model and bench.
// Assumes adcsq_defines.svh is on the include path.
`include "adcsq_defines.svh"

package adcsq_pkg;

	typedef enum logic [2:0] {
		ST_FETCH,
		ST_CHECK,
		ST_CAL,
		ST_TIMER,
		ST_ACQ,
		ST_CMP1,
		ST_LIM2,
		ST_CONV
	} adcsq_state_t;

	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [`ADCSQ_ADR_W-1:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} adcsq_wb_req_t;

	// Sixteen bits: D 15:12, watch 11, timer enable 9, reduced 8, loop 1, pause 0
	typedef struct packed {
		logic [3:0] acq;
		logic watch;
		logic rsv;
		logic timer_en;
		logic reduced;
		logic [5:0] lo;
		logic loop;
		logic pause;
	} adcsq_instr_t;

endpackage

// File: adcsq_cnt.sv
// Down counter that times one sequencer state.
// Assumes a single clock; load takes priority over counting.
`timescale 1ns/1ps
`default_nettype none

module adcsq_cnt #(
	parameter int W = 22
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rstn,
	input wire logic ce,
	// Control
	input wire logic load,
	input wire logic [W-1:0] load_val,
	// Status
	output logic zero
);

	logic [W-1:0] cnt_r;
	logic [W-1:0] cnt_nxt;

	assign zero = (cnt_r == '0);
	assign cnt_nxt = load ? load_val : (zero ? cnt_r : cnt_r - W'(1));

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			cnt_r <= '0;
		end else if (ce) begin
			cnt_r <= cnt_nxt;
		end
	end

endmodule

`default_nettype wire

// File: adcsq_seq.sv
// Instruction sequencer of a self-calibrating converter with a Wishbone slave.
// Assumes a classic Wishbone master on mclk and a converter core that follows
// the state and instruction outputs.
`timescale 1ns/1ps
`include "adcsq_defines.svh"
`default_nettype none

module adcsq_seq
	import adcsq_pkg::*;
#(
	parameter int FULL_CAL_CYC = `ADCSQ_FULL_CAL_CYC,
	parameter int SLOTS = 8
) (
	// Clock, reset, enable
	input wire logic mclk,
	input wire logic rstn,
	input wire logic ce,
	// Wishbone slave
	input wire adcsq_wb_req_t wb_req,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Converter core
	output adcsq_state_t seq_state_o,
	output adcsq_instr_t seq_instr_o,
	output logic [2:0] seq_ip_o,
	output logic seq_run_o
);

	localparam int CW = `ADCSQ_CNT_W;

	// ****************************************
	// Declarations
	// ****************************************
	adcsq_state_t state_r;
	adcsq_state_t state_nxt;
	logic [2:0] ip_r;
	logic [2:0] ip_nxt;
	logic [15:0] cfg_r;
	logic [15:0] cfg_nxt;
	logic [15:0] tmr_r;
	logic [15:0] tmr_nxt;
	logic [15:0] ram_r [SLOTS];
	adcsq_instr_t ins_r;
	adcsq_instr_t ins_nxt;
	logic paused_r;
	logic paused_nxt;
	logic ack_r;
	logic [31:0] dat_r;
	logic [31:0] rd_mux;

	// ****************************************
	// Functions
	// ****************************************
	// Cycles spent in a state, minus one, as loaded into the counter
	function automatic logic [CW-1:0] dur_m1(input adcsq_state_t s,
		input adcsq_instr_t i, input logic [15:0] cfg, input logic [15:0] tmr);
		logic [CW-1:0] d;
		d = CW'(1);
		case (s)
			ST_CAL: begin
				if (cfg[`ADCSQ_CFG_FULL_CAL]) begin
					d = CW'(FULL_CAL_CYC);
				end else begin
					d = CW'(`ADCSQ_SHORT_CAL_CYC);
				end
			end
			ST_TIMER: begin
				d = CW'(`ADCSQ_TMR_MUL) * CW'(tmr) + CW'(`ADCSQ_TMR_ADD);
			end
			ST_ACQ: begin
				if (i.reduced || i.watch) begin
					d = CW'(`ADCSQ_ACQ_RED_ADD) + CW'({i.acq, 1'b0});
				end else begin
					d = CW'(`ADCSQ_ACQ_FULL_ADD) + CW'({i.acq, 1'b0});
				end
			end
			ST_CMP1: begin
				d = CW'(`ADCSQ_CMP1_CYC);
			end
			ST_LIM2: begin
				d = CW'(`ADCSQ_LIM2_CYC);
			end
			ST_CONV: begin
				if (i.watch) begin
					d = CW'(`ADCSQ_CONV_WATCH_CYC);
				end else if (i.reduced) begin
					d = CW'(`ADCSQ_CONV_RED_CYC);
				end else begin
					d = CW'(`ADCSQ_CONV_FULL_CYC);
				end
			end
			default: begin
				d = CW'(1);
			end
		endcase
		return d - CW'(1);
	endfunction

	// Next timed state after a given one, skipping optional states
	function automatic adcsq_state_t follow(input adcsq_state_t s,
		input adcsq_instr_t i, input logic cal_req);
		adcsq_state_t n;
		n = ST_FETCH;
		case (s)
			ST_CHECK: begin
				if (cal_req) begin
					n = ST_CAL;
				end else if (i.timer_en) begin
					n = ST_TIMER;
				end else begin
					n = ST_ACQ;
				end
			end
			ST_CAL: begin
				n = i.timer_en ? ST_TIMER : ST_ACQ;
			end
			ST_TIMER: begin
				n = ST_ACQ;
			end
			ST_ACQ: begin
				n = ST_CMP1;
			end
			ST_CMP1: begin
				n = ST_LIM2;
			end
			ST_LIM2: begin
				n = ST_CONV;
			end
			default: begin
				n = ST_FETCH;
			end
		endcase
		return n;
	endfunction

	// ****************************************
	// Bus decode
	// ****************************************
	wire bus_req = wb_req.cyc && wb_req.stb;
	wire bus_wr = bus_req && wb_req.we && ack_r;
	wire lane_lo = wb_req.sel[0];
	wire lane_hi = wb_req.sel[1];
	wire hit_cfg = (wb_req.adr == `ADCSQ_OFS_CONFIG);
	wire hit_tmr = (wb_req.adr == `ADCSQ_OFS_TIMER);
	wire hit_stat = (wb_req.adr == `ADCSQ_OFS_STATUS);
	wire hit_ram = (wb_req.adr[7:5] == `ADCSQ_RAM_BASE_HI) && (wb_req.adr[1:0] == 2'h0);
	wire [2:0] ram_idx = wb_req.adr[4:2];
	wire wr_cfg = bus_wr && hit_cfg;
	wire wr_tmr = bus_wr && hit_tmr;
	wire wr_ram = bus_wr && hit_ram;
	wire [15:0] wr_mask = {{8{lane_hi}}, {8{lane_lo}}};
	wire [15:0] wr_data = wb_req.dat[15:0];

	// Writing one to the reset flag
	wire soft_reset = wr_cfg && lane_lo && wr_data[`ADCSQ_CFG_RESET];

	// ****************************************
	// Status word
	// ****************************************
	wire cal_req = cfg_r[`ADCSQ_CFG_SHORT_CAL] || cfg_r[`ADCSQ_CFG_SHORT_CAL_ALT]
		|| cfg_r[`ADCSQ_CFG_FULL_CAL];
	wire start = cfg_r[`ADCSQ_CFG_START];
	wire [15:0] status_word = {5'h00, ip_r, 5'h00, paused_r, (state_r == ST_CAL), start};

	always_comb begin
		rd_mux = 32'h00000000;
		if (hit_cfg) begin
			rd_mux = {16'h0000, cfg_r};
		end else if (hit_tmr) begin
			rd_mux = {16'h0000, tmr_r};
		end else if (hit_stat) begin
			rd_mux = {16'h0000, status_word};
		end else if (hit_ram) begin
			rd_mux = {16'h0000, ram_r[ram_idx]};
		end
	end

	// ****************************************
	// Sequencer control
	// ****************************************
	logic cnt_load;
	logic cnt_zero;
	adcsq_state_t load_state;
	wire [CW-1:0] cnt_val = dur_m1(load_state, ins_nxt, cfg_r, tmr_r);
	wire adcsq_instr_t ram_word = adcsq_instr_t'(ram_r[ip_r]);
	wire pause_hit = ins_r.pause && !paused_r;
	wire go = start && !pause_hit;
	wire ins_done = (state_r == ST_CONV) && cnt_zero;

	always_comb begin
		state_nxt = state_r;
		ip_nxt = ip_r;
		ins_nxt = ins_r;
		paused_nxt = paused_r;
		cnt_load = 1'b0;
		load_state = ST_FETCH;
		case (state_r)
			ST_FETCH: begin
				ins_nxt = ram_word;
				state_nxt = ST_CHECK;
			end
			ST_CHECK: begin
				if (pause_hit && start) begin
					paused_nxt = 1'b1;
				end
				if (go) begin
					state_nxt = follow(ST_CHECK, ins_r, cal_req);
					cnt_load = 1'b1;
					load_state = state_nxt;
					paused_nxt = 1'b0;
				end
			end
			ST_CAL, ST_TIMER, ST_ACQ, ST_CMP1, ST_LIM2: begin
				if (cnt_zero) begin
					state_nxt = follow(state_r, ins_r, cal_req);
					cnt_load = 1'b1;
					load_state = state_nxt;
				end
			end
			ST_CONV: begin
				if (cnt_zero) begin
					state_nxt = ST_FETCH;
					if (ins_r.loop) begin
						ip_nxt = 3'h0;
					end else begin
						ip_nxt = ip_r + 3'h1;
					end
				end
			end
			default: begin
				state_nxt = ST_FETCH;
			end
		endcase
		if (soft_reset) begin
			state_nxt = ST_FETCH;
			ip_nxt = 3'h0;
			paused_nxt = 1'b0;
			cnt_load = 1'b0;
		end
	end

	// ****************************************
	// Configuration and timer registers
	// ****************************************
	always_comb begin
		cfg_nxt = cfg_r;
		if (wr_cfg) begin
			cfg_nxt = (cfg_r & ~wr_mask) | (wr_data & wr_mask);
		end
		if (state_r == ST_CAL && cnt_zero && !wr_cfg) begin
			cfg_nxt[`ADCSQ_CFG_SHORT_CAL] = 1'b0;
			cfg_nxt[`ADCSQ_CFG_FULL_CAL] = 1'b0;
		end
		if (state_r == ST_CHECK && pause_hit && start && !wr_cfg) begin
			cfg_nxt[`ADCSQ_CFG_START] = 1'b0;
		end
		if (soft_reset) begin
			cfg_nxt[`ADCSQ_CFG_START] = 1'b0;
		end
		cfg_nxt[`ADCSQ_CFG_RESET] = 1'b0;
	end

	assign tmr_nxt = wr_tmr ? ((tmr_r & ~wr_mask) | (wr_data & wr_mask)) : tmr_r;

	// ****************************************
	// State timer
	// ****************************************
	adcsq_cnt #(
		.W(CW)
	) u_cnt (
		.mclk(mclk),
		.rstn(rstn),
		.ce(ce),
		.load(cnt_load),
		.load_val(cnt_val),
		.zero(cnt_zero)
	);

	// ****************************************
	// Flip-flops
	// ****************************************
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			state_r <= ST_FETCH;
			ip_r <= 3'h0;
			ins_r <= adcsq_instr_t'(`ADCSQ_INS_RESET_VAL);
			paused_r <= 1'b0;
		end else if (ce) begin
			state_r <= state_nxt;
			ip_r <= ip_nxt;
			ins_r <= ins_nxt;
			paused_r <= paused_nxt;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			cfg_r <= `ADCSQ_CFG_RESET_VAL;
			tmr_r <= 16'h0000;
		end else if (ce) begin
			cfg_r <= cfg_nxt;
			tmr_r <= tmr_nxt;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			for (int k = 0; k < SLOTS; k++) begin
				ram_r[k] <= `ADCSQ_INS_RESET_VAL;
			end
		end else if (ce && wr_ram) begin
			ram_r[ram_idx] <= (ram_r[ram_idx] & ~wr_mask) | (wr_data & wr_mask);
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			ack_r <= 1'b0;
			dat_r <= 32'h00000000;
		end else if (ce) begin
			ack_r <= bus_req && !ack_r;
			if (bus_req && !ack_r) begin
				dat_r <= rd_mux;
			end
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign wb_ack_o = ack_r;
	assign wb_dat_o = dat_r;
	assign seq_state_o = state_r;
	assign seq_instr_o = ins_r;
	assign seq_ip_o = ip_r;
	assign seq_run_o = start;

endmodule

`default_nettype wire

// File: adcsq_core_mdl.sv
// Converter core model: times each sequencer state it is told to run.
// Assumes the sequencer state output on mclk.
`timescale 1ns/1ps
`default_nettype none
module adcsq_core_mdl
	import adcsq_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// State in, timing out
	input wire adcsq_state_t st_i,
	output logic done_o,
	output adcsq_state_t st_o,
	output logic [21:0] dur_o
);
	adcsq_state_t prv_r;
	logic [21:0] cnt_r;
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			prv_r <= ST_FETCH;
			cnt_r <= 22'h0;
			done_o <= 1'b0;
			st_o <= ST_FETCH;
			dur_o <= 22'h0;
		end else begin
			prv_r <= st_i;
			cnt_r <= (st_i != prv_r) ? 22'h1 : cnt_r + 22'h1;
			done_o <= st_i != prv_r;
			if (st_i != prv_r) begin
				st_o <= prv_r;
				dur_o <= cnt_r;
			end
		end
	end
endmodule
`default_nettype wire

// File: adcsq_seq_assertions.sv
// Checker of sequencer state timing and pointer stepping.
// Assumes binding to adcsq_seq with ce held high.
`timescale 1ns/1ps
`default_nettype none
module adcsq_seq_chk
	import adcsq_pkg::*;
#(
	parameter int FULL_CAL_CYC = 4944,
	parameter int SLOTS = 8
) (
	// Watched ports
	input wire logic mclk,
	input wire logic rstn,
	input wire logic ce,
	input wire adcsq_wb_req_t wb_req,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire adcsq_state_t seq_state_o,
	input wire adcsq_instr_t seq_instr_o,
	input wire logic [2:0] seq_ip_o,
	input wire logic seq_run_o
);
	adcsq_state_t prev_r;
	adcsq_instr_t ins_r;
	logic [21:0] run_r;
	wire chg = seq_state_o != prev_r;
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			prev_r <= ST_FETCH;
			ins_r <= '0;
			run_r <= 22'h0;
		end else begin
			prev_r <= seq_state_o;
			ins_r <= seq_instr_o;
			run_r <= chg ? 22'h1 : run_r + 22'h1;
		end
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);
	a_fetch_one: assert property (seq_state_o == ST_FETCH |=> seq_state_o != ST_FETCH)
		else $error("fetch not one cycle");
	a_check_one: assert property (seq_state_o == ST_CHECK && seq_run_o && !seq_instr_o.pause
		|=> seq_state_o != ST_CHECK) else $error("check not one cycle");
	a_cal_len: assert property (chg && prev_r == ST_CAL
		|-> run_r == 76 || run_r == FULL_CAL_CYC) else $error("bad calibration length");
	a_acq_len: assert property (chg && prev_r == ST_ACQ |-> run_r ==
		((ins_r.watch || ins_r.reduced) ? 2 : 9) + 2 * ins_r.acq) else $error("bad acq length");
	a_cmp1_len: assert property (chg && seq_state_o == ST_CMP1
		|-> (seq_state_o == ST_CMP1) [*5] ##1 seq_state_o == ST_LIM2) else $error("bad cmp1");
	a_lim2_one: assert property (seq_state_o == ST_LIM2 |=> seq_state_o == ST_CONV)
		else $error("limit read not one cycle");
	a_conv_len: assert property (chg && prev_r == ST_CONV |-> run_r ==
		(ins_r.watch ? 5 : ins_r.reduced ? 21 : 44)) else $error("bad conversion length");
	a_ip_step: assert property (seq_state_o == ST_FETCH && prev_r == ST_CONV
		|-> seq_ip_o == ($past(seq_instr_o.loop) ? 3'h0 : $past(seq_ip_o) + 3'h1))
		else $error("bad pointer step");
	a_timer_gate: assert property (chg && seq_state_o == ST_TIMER |-> ins_r.timer_en)
		else $error("timer without enable");
	a_state_order: assert property (chg |-> seq_state_o > prev_r || seq_state_o == ST_FETCH)
		else $error("state order broken");
	c_cal: cover property (chg && prev_r == ST_CAL);
	c_timer: cover property (chg && prev_r == ST_TIMER);
	c_wrap: cover property (seq_ip_o == 3'h0 && $past(seq_ip_o) == 3'h7);
endmodule
bind adcsq_seq adcsq_seq_chk #(.FULL_CAL_CYC(FULL_CAL_CYC), .SLOTS(SLOTS)) chk_u (
	.mclk(mclk), .rstn(rstn), .ce(ce), .wb_req(wb_req), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .seq_state_o(seq_state_o), .seq_instr_o(seq_instr_o),
	.seq_ip_o(seq_ip_o), .seq_run_o(seq_run_o));
`default_nettype wire

// File: tb_adc_instruction_sequencer.sv
// Self-checking bench of the instruction sequencer.
// Assumes package, design, checker and core model compile first.
`timescale 1ns/1ps
`include "adcsq_defines.svh"
`default_nettype none
module tb_adc_instruction_sequencer;
	import adcsq_pkg::*;
	localparam int FCAL = 20;
	logic mclk = 1'b0;
	logic rstn = 1'b0;
	adcsq_wb_req_t wb_req = '0;
	logic [31:0] wb_dat_o, rd;
	logic wb_ack_o, seq_run_o, done_o;
	adcsq_state_t seq_state_o, st_o;
	adcsq_instr_t seq_instr_o;
	logic [2:0] seq_ip_o;
	logic [21:0] dur_o;
	int fails = 0;
	int n_compared = 0;
	int cycles = 0;
	adcsq_seq #(.FULL_CAL_CYC(FCAL)) dut_u (.mclk(mclk), .rstn(rstn), .ce(1'b1),
		.wb_req(wb_req), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .seq_state_o(seq_state_o),
		.seq_instr_o(seq_instr_o), .seq_ip_o(seq_ip_o), .seq_run_o(seq_run_o));
	adcsq_core_mdl core_u (.mclk(mclk), .rstn(rstn), .st_i(seq_state_o), .done_o(done_o),
		.st_o(st_o), .dur_o(dur_o));
	initial forever #12.5 mclk = ~mclk;
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			end_of_test();
		end
	end
	task automatic end_of_test();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
		@(posedge mclk);
		wb_req <= '{1'b1, 1'b1, we, adr, 4'hF, dat};
		do @(posedge mclk); while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_req <= '0;
	endtask
	task automatic ram(input int i, input logic [15:0] v);
		wb(1'b1, {`ADCSQ_RAM_BASE_HI, 3'(i), 2'b00}, {16'h0000, v});
	endtask
	task automatic til_end(input adcsq_state_t s);
		do @(posedge mclk); while (!(done_o === 1'b1 && st_o === s));
	endtask
	task automatic ip_next(input logic [2:0] e);
		logic [2:0] o;
		o = seq_ip_o;
		do @(posedge mclk); while (seq_ip_o === o);
		chk(32'(seq_ip_o), 32'(e));
	endtask
	task automatic t_wrap();
		for (int i = 0; i < 8; i++)
			ram(i, {4'(i), 12'h000});
		wb(1'b1, `ADCSQ_OFS_CONFIG, 32'h1);
		for (int k = 1; k <= 8; k++) begin
			ip_next(3'(k));
			wb(1'b0, `ADCSQ_OFS_STATUS, 32'h0);
			chk(32'(rd[10:8]), 32'(k % 8));
		end
		wb(1'b1, `ADCSQ_OFS_CONFIG, 32'h0);
		do @(posedge mclk); while (seq_state_o !== ST_CHECK);
		wb(1'b1, `ADCSQ_OFS_CONFIG, 32'h2);
		wb(1'b0, `ADCSQ_OFS_STATUS, 32'h0);
		chk(rd, 32'h0);
	endtask
	task automatic t_loop_pause();
		ram(1, 16'h0002);
		wb(1'b1, `ADCSQ_OFS_CONFIG, 32'h1);
		ip_next(3'h1);
		ip_next(3'h0);
		ip_next(3'h1);
		ram(0, 16'h0001);
		ip_next(3'h0);
		repeat (4) @(posedge mclk);
		chk(32'(seq_run_o), 32'h0);
		chk(32'(seq_state_o), 32'(ST_CHECK));
		wb(1'b0, `ADCSQ_OFS_STATUS, 32'h0);
		chk(rd, 32'h4);
	endtask
	task automatic t_modes();
		ram(0, 16'h3300);
		ram(1, 16'h0802);
		wb(1'b1, `ADCSQ_OFS_TIMER, 32'h2);
		wb(1'b1, `ADCSQ_OFS_CONFIG, 32'h2);
		wb(1'b1, `ADCSQ_OFS_CONFIG, 32'h1);
		til_end(ST_TIMER);
		chk(32'(dur_o), 32'd66);
		til_end(ST_ACQ);
		chk(32'(dur_o), 32'd8);
		til_end(ST_CONV);
		chk(32'(dur_o), 32'd21);
		til_end(ST_CONV);
		chk(32'(dur_o), 32'd5);
	endtask
	task automatic t_cal();
		wb(1'b1, `ADCSQ_OFS_CONFIG, 32'h5);
		til_end(ST_CAL);
		chk(32'(dur_o), 32'd76);
		wb(1'b1, `ADCSQ_OFS_CONFIG, 32'h9);
		til_end(ST_CAL);
		chk(32'(dur_o), 32'(FCAL));
		til_end(ST_CHECK);
		chk(32'(seq_state_o == ST_CAL), 32'h0);
	endtask
	initial begin
		repeat (6) @(posedge mclk);
		rstn <= 1'b1;
		wb(1'b0, `ADCSQ_OFS_STATUS, 32'h0);
		chk(rd, 32'h0);
		wb(1'b0, 8'h0C, 32'h0);
		chk(rd, 32'h0);
		t_wrap();
		t_loop_pause();
		t_modes();
		t_cal();
		end_of_test();
	end
endmodule
`default_nettype wire
